//--- rtl/smc_consts.svh
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_PUSH_CYCLES 2
`define SMC_POP_CYCLES 2
`define SMC_SINGLE_CYCLES 1
`define SMC_SP_RESET 16'h10FF
`define SMC_DATA_W 8
`define SMC_REG_AW 5
`define SMC_IO_AW 6
`define SMC_SP_W 16
`endif

//--- rtl/smc_pkg.sv
`include "smc_consts.svh"
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_OP_NOP,
        SMC_OP_IN,
        SMC_OP_OUT,
        SMC_OP_PUSH,
        SMC_OP_POP,
        SMC_OP_SLEEP,
        SMC_OP_WATCHDOG,
        SMC_OP_BREAK
    } smc_op_type;

    typedef struct packed {
        smc_op_type op;
        logic [`SMC_REG_AW-1:0] reg_sel;
        logic [`SMC_IO_AW-1:0] io_addr;
    } smc_cmd_type;

    typedef struct packed {
        logic we;
        logic [`SMC_REG_AW-1:0] addr;
        logic [`SMC_DATA_W-1:0] data;
    } smc_rf_wr_type;

    typedef struct packed {
        logic we;
        logic re;
        logic [`SMC_SP_W-1:0] addr;
        logic [`SMC_DATA_W-1:0] data;
    } smc_mem_type;

    typedef struct packed {
        logic we;
        logic re;
        logic [`SMC_IO_AW-1:0] addr;
        logic [`SMC_DATA_W-1:0] data;
    } smc_io_type;
endpackage : smc_pkg

//--- rtl/smc_stack_ptr.sv
`timescale 1ns/100ps
`include "smc_consts.svh"
// ============================================================
// Stack pointer: post-decrement push, pre-increment pop
module smc_stack_ptr #(
    parameter logic [`SMC_SP_W-1:0] SP_RESET = `SMC_SP_RESET
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    output logic [`SMC_SP_W-1:0] sp,
    output logic [`SMC_SP_W-1:0] sp_pop_addr
);
    logic [`SMC_SP_W-1:0] sp_q;
    logic [`SMC_SP_W-1:0] sp_d;

    always_comb begin
        sp_d = sp_q;
        if (push) begin
            sp_d = sp_q - `SMC_SP_W'(1);
        end else if (pop) begin
            sp_d = sp_q + `SMC_SP_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sp_q <= SP_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    assign sp = sp_q;
    assign sp_pop_addr = sp_q + `SMC_SP_W'(1);
endmodule : smc_stack_ptr

//--- rtl/smc_exec.sv
// Operation
// [RQ1] Push stores source register, 2 cycles, flags kept
// [RQ2] Pop loads destination register, 2 cycles, flags kept
// [RQ3] Sleep one cycle, hands to sleep controller
// [RQ4] Watchdog restart one cycle, pulses watchdog
// [RQ5] Break acts only with debug enabled
// [RQ6] In/out copy one cycle; nop does nothing
`timescale 1ns/100ps
`include "smc_consts.svh"
module smc_exec (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire smc_pkg::smc_cmd_type cmd,
    output logic cmd_ready,
    input wire logic [`SMC_DATA_W-1:0] src_reg,
    input wire logic [`SMC_DATA_W-1:0] io_rdata,
    input wire logic [`SMC_DATA_W-1:0] mem_rdata,
    input wire logic debug_en,
    output smc_pkg::smc_rf_wr_type rf_wr,
    output smc_pkg::smc_mem_type mem,
    output smc_pkg::smc_io_type io,
    output logic [`SMC_SP_W-1:0] sp,
    output logic sleep_req,
    output logic watchdog_restart_op,
    output logic debug_break,
    output logic flags_we,
    output logic busy
);
    // ============================================================
    // State
    typedef enum logic [1:0] {
        SMC_ST_IDLE,
        SMC_ST_PUSH2,
        SMC_ST_POP2
    } smc_state_type;

    smc_state_type state_q, state_d;
    logic [`SMC_REG_AW-1:0] dst_q, dst_d;
    smc_pkg::smc_rf_wr_type rf_q, rf_d;
    smc_pkg::smc_mem_type mem_q, mem_d;
    smc_pkg::smc_io_type io_q, io_d;
    logic sleep_q, sleep_d;
    logic wdog_q, wdog_d;
    logic brk_q, brk_d;
    logic take;
    logic sp_push;
    logic sp_pop;
    logic [`SMC_SP_W-1:0] sp_pop_addr;

    // ============================================================
    // Stack pointer
    smc_stack_ptr u_sp (
        .core_clk(core_clk),
        .rst(rst),
        .push(sp_push),
        .pop(sp_pop),
        .sp(sp),
        .sp_pop_addr(sp_pop_addr)
    );

    assign cmd_ready = (state_q == SMC_ST_IDLE);
    assign take = cmd_valid && cmd_ready;
    assign busy = !cmd_ready;
    // None of these operations touches status flags
    assign flags_we = 1'b0; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5]

    // ============================================================
    // Sequence: state, write-back target, stack pointer moves
    always_comb begin
        state_d = state_q;
        dst_d = dst_q;
        sp_push = 1'b0;
        sp_pop = 1'b0;
        unique case (state_q)
            SMC_ST_IDLE: begin
                if (take) begin
                    unique case (cmd.op)
                        smc_pkg::SMC_OP_IN: begin
                            dst_d = cmd.reg_sel; // [RQ6]
                        end
                        smc_pkg::SMC_OP_PUSH: begin
                            sp_push = 1'b1; // [RQ1]
                            state_d = SMC_ST_PUSH2; // [RQ1]
                        end
                        smc_pkg::SMC_OP_POP: begin
                            sp_pop = 1'b1; // [RQ2]
                            dst_d = cmd.reg_sel;
                            state_d = SMC_ST_POP2; // [RQ2]
                        end
                        smc_pkg::SMC_OP_NOP,
                        smc_pkg::SMC_OP_OUT,
                        smc_pkg::SMC_OP_SLEEP,
                        smc_pkg::SMC_OP_WATCHDOG,
                        smc_pkg::SMC_OP_BREAK: begin
                            state_d = SMC_ST_IDLE; // [RQ3] [RQ4] [RQ6]
                        end
                    endcase
                end
            end
            SMC_ST_PUSH2: begin
                state_d = SMC_ST_IDLE; // [RQ1]
            end
            SMC_ST_POP2: begin
                state_d = SMC_ST_IDLE; // [RQ2]
            end
            default: begin
                state_d = SMC_ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // Sequence registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= SMC_ST_IDLE;
            dst_q <= '0;
        end else begin
            state_q <= state_d;
            dst_q <= dst_d;
        end
    end

    // ============================================================
    // Access strobes
    always_comb begin
        rf_d = '0;
        mem_d = '0;
        io_d = '0;
        sleep_d = 1'b0;
        wdog_d = 1'b0;
        brk_d = 1'b0;
        if (take) begin
            unique case (cmd.op)
                smc_pkg::SMC_OP_NOP: begin
                    io_d = '0; // [RQ6]
                end
                smc_pkg::SMC_OP_IN: begin
                    io_d.re = 1'b1; // [RQ6]
                    io_d.addr = cmd.io_addr;
                end
                smc_pkg::SMC_OP_OUT: begin
                    io_d.we = 1'b1; // [RQ6]
                    io_d.addr = cmd.io_addr;
                    io_d.data = src_reg;
                end
                smc_pkg::SMC_OP_PUSH: begin
                    mem_d.we = 1'b1; // [RQ1]
                    mem_d.addr = sp;
                    mem_d.data = src_reg;
                end
                smc_pkg::SMC_OP_POP: begin
                    mem_d.re = 1'b1; // [RQ2]
                    mem_d.addr = sp_pop_addr;
                end
                smc_pkg::SMC_OP_SLEEP: begin
                    sleep_d = 1'b1; // [RQ3]
                end
                smc_pkg::SMC_OP_WATCHDOG: begin
                    wdog_d = 1'b1; // [RQ4]
                end
                smc_pkg::SMC_OP_BREAK: begin
                    brk_d = debug_en; // [RQ5]
                end
            endcase
        end
        // Pop write-back in its second cycle
        if (state_q == SMC_ST_POP2) begin
            rf_d.we = 1'b1; // [RQ2]
            rf_d.addr = dst_q;
            rf_d.data = mem_rdata;
        end
        // Port input write-back one cycle after the read
        if (io_q.re) begin
            rf_d.we = 1'b1; // [RQ6]
            rf_d.addr = dst_q;
            rf_d.data = io_rdata;
        end
    end

    // ============================================================
    // Strobe registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rf_q <= '0;
            mem_q <= '0;
            io_q <= '0;
            sleep_q <= 1'b0;
            wdog_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            rf_q <= rf_d;
            mem_q <= mem_d;
            io_q <= io_d;
            sleep_q <= sleep_d;
            wdog_q <= wdog_d;
            brk_q <= brk_d;
        end
    end

    assign rf_wr = rf_q;
    assign mem = mem_q;
    assign io = io_q;
    assign sleep_req = sleep_q;
    assign watchdog_restart_op = wdog_q;
    assign debug_break = brk_q;
endmodule : smc_exec

//--- sim/smc_exec_props.sv
`timescale 1ns/100ps
// ============================================================
// Checker on the operation ports
module smc_exec_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire smc_pkg::smc_cmd_type cmd,
    input wire logic cmd_ready,
    input wire logic [7:0] src_reg,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] mem_rdata,
    input wire logic debug_en,
    input wire smc_pkg::smc_rf_wr_type rf_wr,
    input wire smc_pkg::smc_mem_type mem,
    input wire smc_pkg::smc_io_type io,
    input wire logic sleep_req,
    input wire logic watchdog_restart_op,
    input wire logic debug_break
);
    logic [7:0] t;
    assign t = (cmd_valid && cmd_ready) ? 8'h01 << cmd.op : 8'h00;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_push_store: assert property (
        t[3] |=> mem.we && mem.data == $past(src_reg) && !cmd_ready
        ##1 cmd_ready) else $error("push store wrong");
    chk_pop_load: assert property (
        t[4] |=> mem.re && !cmd_ready
        ##1 rf_wr.we && rf_wr.data == $past(mem_rdata) && cmd_ready)
        else $error("pop load wrong");
    chk_sleep_pulse: assert property (
        t[5] |=> sleep_req && cmd_ready) else $error("no sleep pulse");
    chk_watchdog_pulse: assert property (
        t[6] |=> watchdog_restart_op) else $error("no watchdog pulse");
    chk_break_gate: assert property (
        t[7] |=> debug_break == $past(debug_en)) else $error("break gate");
    chk_in_copy: assert property (
        t[1] |=> io.re ##1 rf_wr.we && rf_wr.data == $past(io_rdata))
        else $error("port input wrong");
    chk_out_copy: assert property (
        t[2] |=> io.we && io.data == $past(src_reg))
        else $error("port output wrong");
endmodule : smc_exec_props

bind smc_exec smc_exec_props chk_u (.*);

//--- sim/smc_mem_model.sv
`timescale 1ns/100ps
// ============================================================
// Stack memory and fixed I/O space
module smc_mem_model (
    input wire logic core_clk,
    input wire smc_pkg::smc_mem_type mem,
    input wire smc_pkg::smc_io_type io,
    output logic [7:0] mem_rdata,
    output logic [7:0] io_rdata
);
    logic [7:0] stk [65536];
    assign mem_rdata = mem.re ? stk[mem.addr] : ~mem.addr[7:0];
    assign io_rdata = io.re ? {2'h0, io.addr} ^ 8'h5A : ~{2'h0, io.addr};
    always @(posedge core_clk) begin
        if (mem.we) stk[mem.addr] <= mem.data;
    end
endmodule : smc_mem_model

//--- sim/tb.sv
`timescale 1ns/100ps
// ============================================================
// Bench
module tb;
    logic core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, debug_en = 1'b0;
    smc_pkg::smc_cmd_type cmd = '0;
    logic [7:0] src_reg = 8'h00, io_rdata, mem_rdata;
    smc_pkg::smc_rf_wr_type rf_wr;
    smc_pkg::smc_mem_type mem;
    smc_pkg::smc_io_type io;
    logic [15:0] sp;
    logic cmd_ready, busy, sleep_req, watchdog_restart_op;
    logic debug_break, flags_we;
    int err_total = 0, comparisons = 0, seed = 32'hFBE3, cyc = 0;
    logic [15:0] sp_m = 16'h10FF;
    logic [7:0] q[$];
    always #5 core_clk = ~core_clk;
    smc_exec dut_u (.*);
    smc_mem_model mdl_u (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask : chk
    task automatic run(input logic [2:0] o);
        logic [7:0] d, v;
        logic [5:0] a;
        logic [9:0] s, e;
        logic [14:0] r, x;
        logic w;
        d = 8'($random(seed));
        a = 6'($random(seed));
        if (o == 3'h4 && q.size() == 0) o = 3'h3;
        cmd_valid <= 1'b1;
        cmd <= {o, a[4:0], a};
        src_reg <= d;
        debug_en <= d[0];
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
        s = {io.we, io.re, mem.we, mem.re, sleep_req, watchdog_restart_op,
            debug_break, cmd_ready, busy, flags_we};
        e = {o == 2, o == 1, o == 3, o == 4, o == 5, o == 6, o == 7 && d[0],
            o != 3 && o != 4, o == 3 || o == 4, 1'b0};
        chk(s, e);
        if (o == 3'h3) begin
            chk({mem.addr, mem.data}, {sp_m, d});
            q.push_back(d);
            sp_m--;
        end
        if (o == 3'h4) sp_m++;
        if (o == 3'h4) chk(mem.addr, sp_m);
        chk(sp, sp_m);
        if (o == 3'h1 || o == 3'h2) chk(io.addr, a);
        if (o == 3'h2) chk(io.data, d);
        w = (o == 3'h1) || (o == 3'h4);
        v = (o == 3'h1) ? {2'h0, a} ^ 8'h5A : 8'h00;
        if (o == 3'h4) v = q.pop_back();
        @(posedge core_clk);
        #1;
        r = {rf_wr.we, cmd_ready, rf_wr.addr & {5{rf_wr.we}},
            rf_wr.data & {8{rf_wr.we}}};
        x = {w, 1'b1, a[4:0] & {5{w}}, v};
        chk(r, x);
        @(posedge core_clk);
    endtask : run
    task automatic finish_test();
        $display("counts: %0d mismatches, %0d comparisons",
            err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) run(3'(i));
        $display("test each op done");
        repeat (80) run(3'($random(seed)));
        $display("test random ops done");
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        sp_m = 16'h10FF;
        q.delete();
        #1;
        chk(sp, sp_m);
        @(posedge core_clk);
        run(3'h3);
        run(3'h4);
        $display("test reset mid run done");
        finish_test();
    end
endmodule : tb
